// ==== shared/pcrc_consts.svh ====
/*
 * register offsets, field positions, reset values and sizes of the programmable crc engine.
 * assumes inclusion by bare name from the shared folder.
 */
`ifndef PCRC_CONSTS_SVH
`define PCRC_CONSTS_SVH

// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define PCRC_OFF_CTRL 4'h0
`define PCRC_OFF_TAPS 4'h1
`define PCRC_OFF_DATA 4'h2
`define PCRC_OFF_RESULT 4'h3
`define PCRC_OFF_IRQ_STAT 4'h4
`define PCRC_OFF_IRQ_MASK 4'h5

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define PCRC_CTL_PLEN_LSB 0
`define PCRC_CTL_GO_BIT 4
`define PCRC_CTL_EMPTY_BIT 6
`define PCRC_CTL_FULL_BIT 7
`define PCRC_CTL_VW_LSB 8

// ----------------------------------------------------------------
// reset values, sizes, wide-length threshold and tap write mask
// ----------------------------------------------------------------
`define PCRC_TAPS_RST 16'h0000
`define PCRC_PLEN_RST 4'h0
`define PCRC_FIFO_DEPTH 16
`define PCRC_FIFO_DEPTH_WIDE 8
`define PCRC_PLEN_WIDE_MIN 4'h7
`define PCRC_TAP_WMASK 16'hfffe

`endif

// ==== shared/pcrc_pkg.sv ====
/*
 * types of the programmable crc engine.
 * assumes no include file; it uses no macro of pcrc_consts.svh.
 */
package pcrc_pkg;

	typedef enum logic [1:0]
	{
		PCRC_IDLE = 2'b00,
		PCRC_LOAD = 2'b01,
		PCRC_SHIFT = 2'b10
	} pcrc_state_t;

	typedef struct packed
	{
		logic [4:0] valid_word_count;
		logic fifo_full_flag;
		logic fifo_empty_flag;
	} pcrc_fifo_stat_t;

	typedef struct packed
	{
		logic full_rise;
		logic empty_rise;
		logic done;
	} pcrc_events_t;

endpackage : pcrc_pkg

// ==== core/pcrc_shifter.sv ====
/*
 * one step of the crc serial shifter with programmable taps.
 * assumes the caller registers the result and qualifies it with its own enable.
 */
`timescale 1ns/1ps
`default_nettype none
module pcrc_shifter
	import pcrc_pkg::*;
(
	input wire logic [15:0] crc_i,
	input wire logic [15:0] taps_i,
	input wire logic [3:0] plen_i,
	input wire logic data_bit_i,
	output logic [15:0] crc_o
);

	logic fb;
	logic [15:0] shifted;

	// feedback taken from the top term of the programmed length
	always_comb
	begin
		fb = crc_i[plen_i] ^ data_bit_i;
		shifted = {crc_i[14:0], 1'b0};
		crc_o = shifted ^ ({16{fb}} & taps_i);
		crc_o[0] = fb;
	end

endmodule : pcrc_shifter
`default_nettype wire

// ==== core/pcrc_top.sv ====
/*
 * programmable crc engine: avalon-mm slave, data fifo, serial shifter and interrupt.
 * assumes a single 125 mhz clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_consts.svh"
module pcrc_top
	import pcrc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire rst_n = rst_sync_q;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0] taps_q, taps_d;
	logic [3:0] plen_q, plen_d;
	logic go_q, go_d;
	logic [15:0] crc_q, crc_d;
	logic [15:0] mem_q [0:`PCRC_FIFO_DEPTH-1];
	logic [3:0] wptr_q, wptr_d, rptr_q, rptr_d;
	logic [4:0] count_q, count_d;
	logic [15:0] sh_word_q, sh_word_d;
	logic [3:0] bit_q, bit_d;
	pcrc_state_t st_q, st_d;
	logic [2:0] stat_q, stat_d;
	logic [2:0] mask_q, mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	pcrc_fifo_stat_t fs;
	pcrc_events_t ev;
	logic [15:0] crc_step;
	logic [4:0] cap;
	logic push, pop, wr_hit, rd_hit;
	logic [4:0] count_nxt;

	pcrc_shifter u_shift
	(
		.crc_i(crc_q),
		.taps_i(taps_q),
		.plen_i(plen_q),
		.data_bit_i(sh_word_q[15]),
		.crc_o(crc_step)
	);

	// ----------------------------------------------------------------
	// bus and fifo next state
	// ----------------------------------------------------------------
	always_comb
	begin
		// one wait cycle per access, answered on the second cycle
		wr_hit = avs_write_i && !ack_q;
		rd_hit = avs_read_i && !ack_q;
		ack_d = (avs_read_i || avs_write_i) && !ack_q;
		avs_waitrequest_o = !ack_q;
		cap = (plen_q > `PCRC_PLEN_WIDE_MIN) ? 5'(`PCRC_FIFO_DEPTH_WIDE)
			: 5'(`PCRC_FIFO_DEPTH);
		fs.valid_word_count = count_q;
		fs.fifo_full_flag = (count_q >= cap);
		fs.fifo_empty_flag = (count_q == 5'h00);
		push = wr_hit && (avs_address_i == `PCRC_OFF_DATA) && !fs.fifo_full_flag;
		pop = (st_q != PCRC_SHIFT) && go_q && !fs.fifo_empty_flag && (st_q == PCRC_IDLE);
		wptr_d = push ? wptr_q + 4'h1 : wptr_q;
		rptr_d = pop ? rptr_q + 4'h1 : rptr_q;
		count_nxt = count_q + {4'h0, push} - {4'h0, pop};
		count_d = count_nxt;
		taps_d = taps_q;
		plen_d = plen_q;
		go_d = go_q;
		mask_d = mask_q;
		crc_d = crc_q;
		if (wr_hit)
		begin
			unique case (avs_address_i)
				`PCRC_OFF_TAPS: taps_d = avs_writedata_i[15:0] & `PCRC_TAP_WMASK;
				`PCRC_OFF_CTRL:
				begin
					plen_d = avs_writedata_i[`PCRC_CTL_PLEN_LSB +: 4];
					go_d = avs_writedata_i[`PCRC_CTL_GO_BIT];
				end
				`PCRC_OFF_RESULT: crc_d = avs_writedata_i[15:0];
				`PCRC_OFF_IRQ_MASK: mask_d = avs_writedata_i[2:0];
				default: ;
			endcase
		end
		// shifter
		st_d = st_q;
		sh_word_d = sh_word_q;
		bit_d = bit_q;
		ev.done = 1'b0;
		unique case (st_q)
			PCRC_IDLE:
				if (pop)
				begin
					sh_word_d = mem_q[rptr_q];
					bit_d = 4'h0;
					st_d = PCRC_SHIFT;
				end
			PCRC_LOAD: st_d = PCRC_IDLE;
			PCRC_SHIFT:
			begin
				crc_d = crc_step;
				sh_word_d = {sh_word_q[14:0], 1'b0};
				bit_d = bit_q + 4'h1;
				if (bit_q == 4'hf)
				begin
					st_d = PCRC_IDLE;
					// stop once the fifo has been drained; a word pushed now keeps it running
					if (count_nxt == 5'h00)
					begin
						// a control write in this cycle keeps the start value it carries
						if (!(wr_hit && avs_address_i == `PCRC_OFF_CTRL))
							go_d = 1'b0;
						ev.done = 1'b1;
					end
				end
			end
			default: st_d = PCRC_IDLE;
		endcase
		ev.full_rise = (count_nxt >= cap) && !fs.fifo_full_flag;
		ev.empty_rise = (count_nxt == 5'h00) && !fs.fifo_empty_flag;
		// set wins over the clear on read
		stat_d = ((rd_hit && avs_address_i == `PCRC_OFF_IRQ_STAT) ? 3'h0 : stat_q)
			| {ev.full_rise, ev.empty_rise, ev.done};
		rdata_d = rdata_q;
		if (rd_hit)
		begin
			unique case (avs_address_i)
				`PCRC_OFF_CTRL: rdata_d = {16'h0000, 3'h0, fs.valid_word_count,
					fs.fifo_full_flag, fs.fifo_empty_flag, 1'b0, go_q, plen_q};
				`PCRC_OFF_TAPS: rdata_d = {16'h0000, taps_q[15:1], 1'b0};
				`PCRC_OFF_RESULT: rdata_d = {16'h0000, crc_q};
				`PCRC_OFF_IRQ_STAT: rdata_d = {29'h0, stat_q};
				`PCRC_OFF_IRQ_MASK: rdata_d = {29'h0, mask_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			taps_q <= `PCRC_TAPS_RST;
			plen_q <= `PCRC_PLEN_RST;
			go_q <= 1'b0;
			crc_q <= 16'h0000;
			wptr_q <= 4'h0;
			rptr_q <= 4'h0;
			count_q <= 5'h00;
			sh_word_q <= 16'h0000;
			bit_q <= 4'h0;
			st_q <= PCRC_IDLE;
			stat_q <= 3'h0;
			mask_q <= 3'h0;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end
		else
		begin
			taps_q <= taps_d;
			plen_q <= plen_d;
			go_q <= go_d;
			crc_q <= crc_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			count_q <= count_d;
			sh_word_q <= sh_word_d;
			bit_q <= bit_d;
			st_q <= st_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	// fifo storage, no reset needed
	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem_q[wptr_q] <= avs_writedata_i[15:0];
	end

	assign avs_readdata_o = rdata_q;
	assign irq_o = |(stat_q & mask_q);

endmodule : pcrc_top
`default_nettype wire

// ==== bench/pcrc_properties.sv ====
/* port checker of the crc engine.
 assumes a bind onto pcrc_top. */
`timescale 1ns/1ps
`default_nettype none
module pcrc_properties
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o
);
	logic [15:0] taps_q;
	logic [15:0] taps_d;
	logic rd_ok;
	logic ctl_rd;
	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	assign rd_ok = avs_read_i && !avs_waitrequest_o;
	assign ctl_rd = rd_ok && avs_address_i == 4'h0;
	// mirror of the tap register as written over the bus
	always_comb
	begin
		taps_d = taps_q;
		if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h1)
			taps_d = avs_writedata_i[15:0] & 16'hfffe;
	end
	always_ff @(posedge mclk_i or negedge nrst_i)
		if (!nrst_i)
			taps_q <= 16'h0000;
		else
			taps_q <= taps_d;
	property p_taps;
		rd_ok && avs_address_i == 4'h1 |-> avs_readdata_o == {16'h0000, taps_q};
	endproperty
	a_taps: assert property (p_taps) else $error("tap readback differs");
	property p_cap;
		ctl_rd |-> avs_readdata_o[12:8] <= 5'h10;
	endproperty
	a_cap: assert property (p_cap) else $error("word count above 16");
	property p_full;
		ctl_rd |-> avs_readdata_o[7]
			== (avs_readdata_o[12:8] >= (avs_readdata_o[3:0] > 4'h7 ? 5'h08 : 5'h10));
	endproperty
	a_full: assert property (p_full) else $error("full flag disagrees");
	property p_empty;
		ctl_rd |-> avs_readdata_o[6] == (avs_readdata_o[12:8] == 5'h00);
	endproperty
	a_empty: assert property (p_empty) else $error("empty flag disagrees");
	property p_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1
			avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("wait not one cycle");
endmodule : pcrc_properties
`default_nettype wire

// ==== bench/tb.sv ====
/* self-checking bench of the crc engine.
 assumes the shared folder on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_consts.svh"
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", nm, e, s); end end
module tb;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic irq_o;
	logic [31:0] q;
	logic [15:0] crc;
	int n_mismatch = 0;
	int total_checks = 0;
	pcrc_top pcrc_top_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
	initial forever #4 mclk_i = ~mclk_i;
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		int n;
		n = 0;
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_address_i <= a;
		avs_writedata_i <= {16'h0000, d};
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20) n_mismatch++;
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge mclk_i);
	endtask : acc
	task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
		acc(1'b0, a, 16'h0000);
		`CHK(nm, {16'h0000, e}, q)
	endtask : rc
	function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] w);
		logic fb;
		for (int i = 15; i >= 0; i--)
		begin
			fb = c[15] ^ w[i];
			c = (c << 1) ^ (fb ? 16'hfffe : 16'h0000);
			c[0] = fb;
		end
		return c;
	endfunction : step
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		rc(`PCRC_OFF_TAPS, 16'h0000, "taps reset");
		acc(1'b1, `PCRC_OFF_TAPS, 16'hffff);
		rc(`PCRC_OFF_TAPS, 16'hfffe, "taps bit0");
		rc(4'hf, 16'h0000, "unmapped");
		$display("test registers done");
		acc(1'b1, `PCRC_OFF_IRQ_MASK, 16'h0004);
		acc(1'b1, `PCRC_OFF_CTRL, 16'h000f);
		acc(1'b1, `PCRC_OFF_RESULT, 16'hc35a);
		crc = 16'hc35a;
		for (int i = 1; i <= 9; i++)
		begin
			acc(1'b1, `PCRC_OFF_DATA, 16'h1111 * i[15:0]);
			if (i < 9) crc = step(crc, 16'h1111 * i[15:0]);
		end
		rc(`PCRC_OFF_CTRL, 16'h088f, "cap 8");
		`CHK("irq full", 1'b1, irq_o)
		acc(1'b0, `PCRC_OFF_IRQ_STAT, 16'h0000);
		`CHK("full event", 1'b1, q[2])
		@(posedge mclk_i);
		`CHK("irq cleared", 1'b0, irq_o)
		$display("test fill done");
		acc(1'b1, `PCRC_OFF_IRQ_MASK, 16'h0001);
		acc(1'b1, `PCRC_OFF_CTRL, 16'h001f);
		for (int n = 0; n < 600 && irq_o !== 1'b1; n++)
			@(posedge mclk_i);
		rc(`PCRC_OFF_CTRL, 16'h004f, "drained");
		rc(`PCRC_OFF_RESULT, crc, "crc");
		acc(1'b0, `PCRC_OFF_IRQ_STAT, 16'h0000);
		`CHK("done event", 1'b1, q[0])
		`CHK("empty event", 1'b1, q[1])
		$display("test shift done");
		acc(1'b1, `PCRC_OFF_CTRL, 16'h0007);
		for (int i = 0; i < 17; i++)
			acc(1'b1, `PCRC_OFF_DATA, 16'h5a5a);
		rc(`PCRC_OFF_CTRL, 16'h1087, "cap 16");
		$display("test deep fill done");
		wrap_up();
	end
endmodule : tb
bind pcrc_top pcrc_properties pcrc_properties_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire
